// ===== src/gdp_data_reg.sv
// one port data register with per-bit write mask
`timescale 1ns/1ps
module gdp_data_reg
    import gdp_pkg::*;
#(
    parameter logic [7:0] WR_MASK = 8'hff,
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic we_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] q_o
);

    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // masked-off bits keep their reset value forever
    always_comb begin
        q_nxt = q_r;
        if (we_i) begin
            q_nxt = (wdata_i & WR_MASK) | (q_r & ~WR_MASK);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign q_o = q_r;

endmodule : gdp_data_reg

// ===== src/gdp_pkg.sv
// shared constants for the port e/f data logic
package gdp_pkg;

    // register word addresses on the plain register port
    localparam logic [3:0] GDP_OFS_E_DATA = 4'h0;
    localparam logic [3:0] GDP_OFS_F_DATA = 4'h1;
    localparam logic [3:0] GDP_OFS_D_TAIL = 4'h2;
    localparam int GDP_ADDR_W = 4;
    localparam int GDP_DATA_W = 8;

    // function field encodings, two bits per pin
    localparam logic [1:0] GDP_MD_OTHER = 2'h0;
    localparam logic [1:0] GDP_MD_OUTPUT = 2'h1;
    localparam logic [1:0] GDP_MD_IN_PULL = 2'h2;
    localparam logic [1:0] GDP_MD_IN_NOPULL = 2'h3;

    // reset values
    localparam logic [7:0] GDP_E_DATA_RST = 8'h00;
    localparam logic [7:0] GDP_F_DATA_RST = 8'h00;
    localparam logic [7:0] GDP_D_DATA_RST = 8'h00;
    localparam logic [7:0] GDP_RDATA_RST = 8'h00;

    // port e: bits 7..1 are pins, bit 0 reserved
    localparam logic [7:0] GDP_E_PIN_MASK = 8'hfe;
    // port e pins that have an output encoding (7,5,4,2,1)
    localparam logic [7:0] GDP_E_OUT_MASK = 8'hb6;
    // port f: bits 3..0 are pins, 7..4 reserved
    localparam logic [7:0] GDP_F_PIN_MASK = 8'h0f;
    localparam logic [7:0] GDP_F_OUT_MASK = 8'h0f;
    // port d tail: only pins 6 and 4 handled here, both input-only
    localparam logic [7:0] GDP_D_PIN_MASK = 8'h50;
    localparam logic [7:0] GDP_D_OUT_MASK = 8'h00;

    // pull direction select value that means pull-up
    localparam logic GDP_PULL_SEL_UP = 1'b1;

endpackage : gdp_pkg

// ===== src/gdp_top.sv
// data logic for port e, port f and the input-only tail of port d
// How it works
// - output-mode pin drives the stored data bit; writes reach the pin
// - output-mode pin reads back the stored register bit
// - other-function mode: read stored bit, write stores only
// - input modes 10 and 11 read the live pin; writes store only
// - only e pins 1,2,4,5,7 can output; e3,e6,d4,d6 input-only, read-only
// - port e bits 7..1 map to pins 7..1, all reset to 0
// - port e bit 0 reserved, always reads 0
// - port f bits 3..0 map to pins 3..0, reset 0, all four modes
// - port f bits 7..4 reserved, always read 0
// - port f resistor up or down by select, on only in mode 10
// - every port e pin has a pull-up enabled by its function field
`timescale 1ns/1ps
module gdp_top
    import gdp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    input wire logic [15:0] E_MODE_I,
    input wire logic [7:0] F_MODE_I,
    input wire logic [3:0] D_TAIL_MODE_I,
    input wire logic [3:0] F_PULL_SEL_I,
    input wire logic [7:0] E_PIN_I,
    input wire logic [3:0] F_PIN_I,
    input wire logic [1:0] D_TAIL_PIN_I,
    output logic [7:0] E_PIN_O,
    output logic [7:0] E_PIN_OE_O,
    output logic [7:0] E_PULLUP_O,
    output logic [3:0] F_PIN_O,
    output logic [3:0] F_PIN_OE_O,
    output logic [3:0] F_PULLUP_O,
    output logic [3:0] F_PULLDN_O,
    output logic [1:0] D_TAIL_PULLUP_O
);

    // per-pin decode helpers
    // shared by all three ports so every code decodes alike

    // field of pin n out of a packed 2-bit-per-pin vector
    function automatic logic [1:0] field_of(input logic [15:0] modes, input int n);
        logic [1:0] f;
        f = modes[2*n +: 2];
        return f;
    endfunction : field_of

    // driver on only in output mode and only where the pin has one
    function automatic logic drives(input logic [1:0] md, input logic capable);
        logic d;
        d = capable && (md == GDP_MD_OUTPUT);
        return d;
    endfunction : drives

    // input modes return the pin level, others the stored bit
    function automatic logic reads_pin(input logic [1:0] md);
        logic r;
        r = (md == GDP_MD_IN_PULL) || (md == GDP_MD_IN_NOPULL);
        return r;
    endfunction : reads_pin

    // resistor on only in input mode 10
    function automatic logic pull_on(input logic [1:0] md);
        logic p;
        p = (md == GDP_MD_IN_PULL);
        return p;
    endfunction : pull_on

    // widened mode and pin views, so every port shares the helpers
    // absent pins get field 00, so they read their zero stored bit
    logic [15:0] e_modes;
    logic [15:0] f_modes;
    logic [15:0] d_modes;
    logic [7:0] f_pins;
    logic [7:0] d_pins;

    assign e_modes = E_MODE_I;
    assign f_modes = {8'h00, F_MODE_I};
    // d tail fields sit at pin positions 4 and 6
    assign d_modes = {2'h0, D_TAIL_MODE_I[3:2], 2'h0, D_TAIL_MODE_I[1:0], 8'h00};
    assign f_pins = {4'h0, F_PIN_I};
    assign d_pins = {1'b0, D_TAIL_PIN_I[1], 1'b0, D_TAIL_PIN_I[0], 4'h0};

    // register bus decode
    // unmapped addresses raise no write enable, so such writes vanish
    logic we_e;
    logic we_f;
    logic we_d;

    assign we_e = WR_I && (ADDR_I == GDP_OFS_E_DATA);
    assign we_f = WR_I && (ADDR_I == GDP_OFS_F_DATA);
    assign we_d = WR_I && (ADDR_I == GDP_OFS_D_TAIL);

    // data registers
    // write masks keep read-only and reserved bits at their reset zero
    logic [7:0] e_data;
    logic [7:0] f_data;
    logic [7:0] d_data;

    // read-only pins (e3, e6) and reserved bit 0 never store
    gdp_data_reg #(
        .WR_MASK(GDP_E_OUT_MASK),
        .RST_VAL(GDP_E_DATA_RST)
    ) u_e_data (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .we_i(we_e),
        .wdata_i(WDATA_I),
        .q_o(e_data)
    );

    gdp_data_reg #(
        .WR_MASK(GDP_F_PIN_MASK),
        .RST_VAL(GDP_F_DATA_RST)
    ) u_f_data (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .we_i(we_f),
        .wdata_i(WDATA_I),
        .q_o(f_data)
    );

    // d tail bits are read-only, so nothing ever stores there
    gdp_data_reg #(
        .WR_MASK(GDP_D_OUT_MASK),
        .RST_VAL(GDP_D_DATA_RST)
    ) u_d_data (
        .clk_i(CLK_I),
        .rst_i(SYS_RST_I),
        .we_i(we_d),
        .wdata_i(WDATA_I),
        .q_o(d_data)
    );

    // per-bit read view of each port
    // input modes show the live pin, the other codes the stored bit
    // absent and reserved bits are masked to zero last
    logic [7:0] e_view;
    logic [7:0] f_view;
    logic [7:0] d_view;

    always_comb begin
        e_view = 8'h00;
        for (int n = 0; n < 8; n++) begin
            if (reads_pin(field_of(e_modes, n))) begin
                e_view[n] = E_PIN_I[n];
            end else begin
                e_view[n] = e_data[n];
            end
        end
        e_view = e_view & GDP_E_PIN_MASK;
    end

    always_comb begin
        f_view = 8'h00;
        for (int n = 0; n < 8; n++) begin
            if (reads_pin(field_of(f_modes, n))) begin
                f_view[n] = f_pins[n];
            end else begin
                f_view[n] = f_data[n];
            end
        end
        f_view = f_view & GDP_F_PIN_MASK;
    end

    always_comb begin
        d_view = 8'h00;
        for (int n = 0; n < 8; n++) begin
            if (reads_pin(field_of(d_modes, n))) begin
                d_view[n] = d_pins[n];
            end else begin
                d_view[n] = d_data[n];
            end
        end
        d_view = d_view & GDP_D_PIN_MASK;
    end

    // read data, valid only in the cycle after the read strobe
    // idle cycles return zero, so a stale value never lingers
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    always_comb begin
        rdata_nxt = GDP_RDATA_RST;
        if (RD_I) begin
            case (ADDR_I)
                GDP_OFS_E_DATA: rdata_nxt = e_view;
                GDP_OFS_F_DATA: rdata_nxt = f_view;
                GDP_OFS_D_TAIL: rdata_nxt = d_view;
                default: rdata_nxt = GDP_RDATA_RST;
            endcase
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            rdata_r <= GDP_RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign RDATA_O = rdata_r;

    // port e pin drive
    // pins follow a mode or data change one clock later
    logic [7:0] e_out_r;
    logic [7:0] e_out_nxt;
    logic [7:0] e_oe_r;
    logic [7:0] e_oe_nxt;
    logic [7:0] e_pu_r;
    logic [7:0] e_pu_nxt;

    always_comb begin
        e_oe_nxt = 8'h00;
        e_pu_nxt = 8'h00;
        for (int n = 0; n < 8; n++) begin
            e_oe_nxt[n] = drives(field_of(e_modes, n), GDP_E_OUT_MASK[n]);
            e_pu_nxt[n] = GDP_E_PIN_MASK[n] && pull_on(field_of(e_modes, n));
        end
        // stored value goes to the pin only where the driver is on
        e_out_nxt = e_data & e_oe_nxt;
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            e_out_r <= GDP_E_DATA_RST;
        end else begin
            e_out_r <= e_out_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            e_oe_r <= 8'h00;
        end else begin
            e_oe_r <= e_oe_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            e_pu_r <= 8'h00;
        end else begin
            e_pu_r <= e_pu_nxt;
        end
    end

    assign E_PIN_O = e_out_r;
    assign E_PIN_OE_O = e_oe_r;
    assign E_PULLUP_O = e_pu_r;

    // port f pin drive and pull direction
    // the select bit only steers; the mode decides if a resistor is on
    // a pin in output mode never has a resistor on
    logic [3:0] f_out_r;
    logic [3:0] f_out_nxt;
    logic [3:0] f_oe_r;
    logic [3:0] f_oe_nxt;
    logic [3:0] f_pu_r;
    logic [3:0] f_pu_nxt;
    logic [3:0] f_pd_r;
    logic [3:0] f_pd_nxt;

    always_comb begin
        f_oe_nxt = 4'h0;
        f_pu_nxt = 4'h0;
        f_pd_nxt = 4'h0;
        for (int n = 0; n < 4; n++) begin
            f_oe_nxt[n] = drives(field_of(f_modes, n), GDP_F_OUT_MASK[n]);
            if (pull_on(field_of(f_modes, n))) begin
                // only one of the two resistors is ever on
                f_pu_nxt[n] = (F_PULL_SEL_I[n] == GDP_PULL_SEL_UP);
                f_pd_nxt[n] = (F_PULL_SEL_I[n] != GDP_PULL_SEL_UP);
            end
        end
        f_out_nxt = f_data[3:0] & f_oe_nxt;
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            f_out_r <= 4'h0;
        end else begin
            f_out_r <= f_out_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            f_oe_r <= 4'h0;
        end else begin
            f_oe_r <= f_oe_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            f_pu_r <= 4'h0;
        end else begin
            f_pu_r <= f_pu_nxt;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            f_pd_r <= 4'h0;
        end else begin
            f_pd_r <= f_pd_nxt;
        end
    end

    assign F_PIN_O = f_out_r;
    assign F_PIN_OE_O = f_oe_r;
    assign F_PULLUP_O = f_pu_r;
    assign F_PULLDN_O = f_pd_r;

    // port d tail: pull-up only, never driven
    // these two pins have no output driver at all
    logic [1:0] d_pu_r;
    logic [1:0] d_pu_nxt;

    always_comb begin
        d_pu_nxt[0] = pull_on(field_of(d_modes, 4));
        d_pu_nxt[1] = pull_on(field_of(d_modes, 6));
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            d_pu_r <= 2'h0;
        end else begin
            d_pu_r <= d_pu_nxt;
        end
    end

    assign D_TAIL_PULLUP_O = d_pu_r;

endmodule : gdp_top

// ===== test/gdp_pin_model.sv
// pin side: external sources, overridden where the block drives
`timescale 1ns/1ps
module gdp_pin_model (
    input wire logic [7:0] e_drv_i,
    input wire logic [7:0] e_oe_i,
    input wire logic [7:0] e_ext_i,
    input wire logic [3:0] f_drv_i,
    input wire logic [3:0] f_oe_i,
    input wire logic [3:0] f_ext_i,
    output logic [7:0] e_lvl_o,
    output logic [3:0] f_lvl_o
);
    assign e_lvl_o = (e_oe_i & e_drv_i) | (~e_oe_i & e_ext_i);
    assign f_lvl_o = (f_oe_i & f_drv_i) | (~f_oe_i & f_ext_i);
endmodule : gdp_pin_model

// ===== test/gdp_top_properties.sv
// concurrent checks on the port e/f data block
`timescale 1ns/1ps
module gdp_top_properties
    import gdp_pkg::*;
(
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic RD_I,
    input wire logic [7:0] RDATA_O,
    input wire logic [15:0] E_MODE_I,
    input wire logic [7:0] F_MODE_I,
    input wire logic [3:0] D_TAIL_MODE_I,
    input wire logic [3:0] F_PULL_SEL_I,
    input wire logic [7:0] E_PIN_I,
    input wire logic [3:0] F_PIN_I,
    input wire logic [7:0] E_PIN_O,
    input wire logic [7:0] E_PIN_OE_O,
    input wire logic [7:0] E_PULLUP_O,
    input wire logic [3:0] F_PIN_O,
    input wire logic [3:0] F_PIN_OE_O,
    input wire logic [3:0] F_PULLUP_O,
    input wire logic [3:0] F_PULLDN_O,
    input wire logic [1:0] D_TAIL_PULLUP_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    logic [7:0] e_out, e_pu, e_in;
    logic [3:0] f_out, f_up, f_dn, f_in;
    logic [1:0] d_pu;
    // expected per-pin selections from the function fields
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            e_out[n] = GDP_E_OUT_MASK[n] && E_MODE_I[2*n +: 2] == GDP_MD_OUTPUT;
            e_pu[n] = GDP_E_PIN_MASK[n] && E_MODE_I[2*n +: 2] == GDP_MD_IN_PULL;
            e_in[n] = GDP_E_PIN_MASK[n] && E_MODE_I[2*n+1];
        end
        for (int n = 0; n < 4; n++) begin
            f_out[n] = F_MODE_I[2*n +: 2] == GDP_MD_OUTPUT;
            f_up[n] = F_MODE_I[2*n +: 2] == GDP_MD_IN_PULL && F_PULL_SEL_I[n];
            f_dn[n] = F_MODE_I[2*n +: 2] == GDP_MD_IN_PULL && !F_PULL_SEL_I[n];
            f_in[n] = F_MODE_I[2*n+1];
        end
        d_pu = {D_TAIL_MODE_I[3:2] == GDP_MD_IN_PULL, D_TAIL_MODE_I[1:0] == GDP_MD_IN_PULL};
    end
    AST_E_RSV: assert property (RD_I && ADDR_I == GDP_OFS_E_DATA |=> !RDATA_O[0])
        else $error("e bit0 not zero");
    AST_F_RSV: assert property (RD_I && ADDR_I == GDP_OFS_F_DATA |=> RDATA_O[7:4] == 4'h0)
        else $error("f upper bits not zero");
    AST_E_IN_READ: assert property (RD_I && ADDR_I == GDP_OFS_E_DATA |=>
        ((RDATA_O ^ $past(E_PIN_I)) & $past(e_in)) == 8'h00) else $error("e input read");
    AST_F_IN_READ: assert property (RD_I && ADDR_I == GDP_OFS_F_DATA |=>
        ((RDATA_O[3:0] ^ $past(F_PIN_I)) & $past(f_in)) == 4'h0) else $error("f input read");
    AST_E_OE: assert property (1'b1 |=> E_PIN_OE_O == $past(e_out))
        else $error("e output enable");
    AST_F_OE: assert property (1'b1 |=> F_PIN_OE_O == $past(f_out))
        else $error("f output enable");
    AST_DRV_MASK: assert property ((E_PIN_O & ~E_PIN_OE_O) == 8'h00
        && (F_PIN_O & ~F_PIN_OE_O) == 4'h0) else $error("drive without enable");
    AST_E_PULL: assert property (1'b1 |=> E_PULLUP_O == $past(e_pu))
        else $error("e pull-up");
    AST_F_PULL: assert property (1'b1 |=> F_PULLUP_O == $past(f_up)
        && F_PULLDN_O == $past(f_dn)) else $error("f pull");
    AST_D_PULL: assert property (1'b1 |=> D_TAIL_PULLUP_O == $past(d_pu))
        else $error("d pull-up");
endmodule : gdp_top_properties

// ===== test/gpio_data_ports_e_f_tb.sv
// self-checking bench for the port e/f data block
`timescale 1ns/1ps
module gpio_data_ports_e_f_tb
    import gdp_pkg::*;
;
    logic CLK_I = 1'b0, SYS_RST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
    logic [3:0] ADDR_I = 4'h0, D_TAIL_MODE_I = 4'h0, F_PULL_SEL_I = 4'h5, F_PIN_I;
    logic [7:0] WDATA_I = 8'h00, F_MODE_I = 8'h00, E_PIN_I, RDATA_O, E_PIN_O, E_PIN_OE_O;
    logic [15:0] E_MODE_I = 16'h0000;
    logic [1:0] D_TAIL_PIN_I = 2'b00, D_TAIL_PULLUP_O;
    logic [7:0] E_PULLUP_O, e_ext = 8'ha5;
    logic [3:0] F_PIN_O, F_PIN_OE_O, F_PULLUP_O, F_PULLDN_O, f_ext = 4'h9;
    int n_mismatch = 0, n_compared = 0;
    gdp_top dut_u (.*);
    gdp_pin_model pins_u (.e_drv_i(E_PIN_O), .e_oe_i(E_PIN_OE_O), .e_ext_i(e_ext),
        .f_drv_i(F_PIN_O), .f_oe_i(F_PIN_OE_O), .f_ext_i(f_ext), .e_lvl_o(E_PIN_I),
        .f_lvl_o(F_PIN_I));
    initial begin
        forever #12.5 CLK_I = ~CLK_I;
    end
    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_I);
        ADDR_I <= a;
        WDATA_I <= d;
        WR_I <= 1'b1;
        @(posedge CLK_I);
        WR_I <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge CLK_I);
        ADDR_I <= a;
        RD_I <= 1'b1;
        @(posedge CLK_I);
        RD_I <= 1'b0;
        // read data stand for this one cycle only
        @(negedge CLK_I);
        chk("read data", RDATA_O, exp);
        @(posedge CLK_I);
    endtask : bus_rd
    task automatic t_out();
        E_MODE_I <= 16'h5555;
        F_MODE_I <= 8'h55;
        bus_wr(GDP_OFS_E_DATA, 8'hff);
        bus_wr(GDP_OFS_F_DATA, 8'hff);
        bus_rd(GDP_OFS_E_DATA, 8'hb6);
        chk("e oe", E_PIN_OE_O, 8'hb6);
        chk("e drive", E_PIN_O, 8'hb6);
        bus_rd(GDP_OFS_F_DATA, 8'h0f);
        bus_wr(GDP_OFS_E_DATA, 8'h22);
        bus_wr(GDP_OFS_F_DATA, 8'h05);
        bus_rd(GDP_OFS_E_DATA, 8'h22);
        chk("e drive", E_PIN_O, 8'h22);
        chk("f drive", {F_PIN_OE_O, F_PIN_O}, 8'hf5);
    endtask : t_out
    task automatic t_modes();
        bus_wr(GDP_OFS_E_DATA, 8'hff);
        bus_wr(GDP_OFS_F_DATA, 8'h0f);
        for (int m = 0; m < 4; m++) begin
            E_MODE_I <= {8{m[1:0]}};
            F_MODE_I <= {4{m[1:0]}};
            if (m == 2) begin
                bus_wr(GDP_OFS_E_DATA, 8'h00);
            end
            bus_rd(GDP_OFS_E_DATA, m > 1 ? e_ext & 8'hfe : 8'hb6);
            bus_rd(GDP_OFS_F_DATA, m > 1 ? {4'h0, f_ext} : 8'h0f);
            chk("e pull", E_PULLUP_O, m == 2 ? 8'hfe : 8'h00);
            chk("f pull", {F_PULLUP_O, F_PULLDN_O}, m == 2 ? 8'h5a : 8'h00);
            chk("e oe", E_PIN_OE_O, m == 1 ? 8'hb6 : 8'h00);
            chk("f oe", {4'h0, F_PIN_OE_O}, m == 1 ? 8'h0f : 8'h00);
        end
        E_MODE_I <= 16'h0000;
        bus_rd(GDP_OFS_E_DATA, 8'h00);
    endtask : t_modes
    task automatic t_tail();
        E_MODE_I <= 16'h1010;
        bus_wr(GDP_OFS_E_DATA, 8'h44);
        bus_rd(GDP_OFS_E_DATA, 8'h04);
        chk("e oe", E_PIN_OE_O, 8'h04);
        D_TAIL_MODE_I <= 4'h5;
        D_TAIL_PIN_I <= 2'b11;
        bus_wr(GDP_OFS_D_TAIL, 8'hff);
        bus_rd(GDP_OFS_D_TAIL, 8'h00);
        D_TAIL_MODE_I <= 4'ha;
        bus_rd(GDP_OFS_D_TAIL, 8'h50);
        chk("d pull", {6'h00, D_TAIL_PULLUP_O}, 8'h03);
        D_TAIL_PIN_I <= 2'b01;
        bus_rd(GDP_OFS_D_TAIL, 8'h10);
        F_MODE_I <= 8'haa;
        F_PULL_SEL_I <= 4'ha;
        bus_rd(GDP_OFS_F_DATA, {4'h0, f_ext});
        chk("f pull", {F_PULLUP_O, F_PULLDN_O}, 8'ha5);
        bus_wr(4'h3, 8'hff);
        bus_rd(4'h3, 8'h00);
        bus_rd(GDP_OFS_E_DATA, 8'h04);
    endtask : t_tail
    initial begin
        repeat (10) @(posedge CLK_I);
        SYS_RST_I <= 1'b0;
        bus_rd(GDP_OFS_E_DATA, 8'h00);
        bus_rd(GDP_OFS_F_DATA, 8'h00);
        chk("e outputs", E_PIN_OE_O | E_PIN_O | E_PULLUP_O, 8'h00);
        t_out();
        t_modes();
        t_tail();
        finish_test();
    end
    initial begin
        #200000;
        n_mismatch++;
        finish_test();
    end
endmodule : gpio_data_ports_e_f_tb
bind gdp_top gdp_top_properties chk_u (.*);
